//--- core/isa_bus_cond.v
`timescale 1ns/10ps
`default_nettype none

module isa_bus_cond (
  input wire clock,
  input wire reset_n,
  input wire scl_s,
  input wire sda_s,
  output wire scl_rise,
  output wire scl_fall,
  output wire start_det,
  output wire stop_det
);

  reg scl_q;
  reg sda_q;

  // One-cycle history of the already synchronised lines
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Data moving while clock stays high marks start or stop
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_det = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det = scl_s & scl_q & ~sda_q & sda_s;

endmodule

`default_nettype wire

//--- core/isa_engine.v
`timescale 1ns/10ps
`default_nettype none
`include "isa_defines.vh"

module isa_engine (
  input wire clock,
  input wire reset_n,
  input wire port_enable,
  input wire [3:0] mode_select_field,
  input wire [1:0] port_c_direction,
  input wire addr_wr,
  input wire [7:0] addr_wdata,
  input wire buf_rd,
  input wire buf_wr,
  input wire [7:0] buf_wdata,
  input wire overflow_clr,
  input wire interrupt_clr,
  input wire clock_release_set,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe_n,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  output reg [7:0] rx_tx_buffer,
  output reg [7:0] slave_address_reg,
  output reg buffer_full_flag,
  output reg receive_overflow_flag,
  output reg update_address_flag,
  output reg port_interrupt_flag,
  output wire [7:0] port_status_reg,
  output wire [7:0] port_control_reg
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_ADDR_LO = 3'd2;
  localparam ST_RX = 3'd3;
  localparam ST_TX = 3'd4;
  // Mode decoding is needed in several places
  function is_slave;
    input [3:0] m;
    begin
      is_slave = (m == `ISA_MODE_SLV7) || (m == `ISA_MODE_SLV10) ||
                 (m == `ISA_MODE_SLV7_SS) || (m == `ISA_MODE_SLV10_SS);
    end
  endfunction
  function is_ten_bit;
    input [3:0] m;
    begin
      is_ten_bit = (m == `ISA_MODE_SLV10) || (m == `ISA_MODE_SLV10_SS);
    end
  endfunction
  function has_ss_int;
    input [3:0] m;
    begin
      has_ss_int = (m == `ISA_MODE_SLV7_SS) || (m == `ISA_MODE_SLV10_SS) ||
                   (m == `ISA_MODE_MST_IDLE);
    end
  endfunction
  wire scl_s;
  wire sda_s;
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  reg [2:0] state;
  reg [3:0] bit_count;
  reg [7:0] serial_shift_reg;
  reg [7:0] tx_shift;
  reg ack_drive;
  reg pend_hit;
  reg scl_hold;
  reg hi_seen;
  reg tx_active;
  reg tx_nack;
  reg rw_status;
  reg data_status;
  reg start_seen;
  reg stop_seen;
  wire two_wire_mode = is_slave(mode_select_field) || (mode_select_field == `ISA_MODE_MST_IDLE);
  wire port_active = port_enable && two_wire_mode;
  wire slave_on = port_active && is_slave(mode_select_field);
  wire ten_bit = is_ten_bit(mode_select_field);
  wire pins_owned = port_active && (port_c_direction == 2'b11);
  // Lines are resynchronised so every flag moves on the system clock
  isa_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .d_in({scl_in, sda_in}),
    .q_out({scl_s, sda_s})
  );
  isa_bus_cond u_cond (
    .clock(clock),
    .reset_n(reset_n),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_det(start_det),
    .stop_det(stop_det)
  );

  // Address compare: 7-bit uses bits 7..1, 10-bit also checks the prefix
  wire hi_prefix = (serial_shift_reg[7:3] == `ISA_HI10_PATTERN);
  wire addr_hit = (serial_shift_reg[7:1] == slave_address_reg[7:1]) && (!ten_bit || hi_prefix);
  wire lo_hit = (serial_shift_reg == slave_address_reg);
  wire rx_state = (state == ST_ADDR) || (state == ST_ADDR_LO) || (state == ST_RX);
  wire eighth_fall = scl_fall && (bit_count == `ISA_BYTE_BITS);
  wire ninth_fall = scl_fall && (bit_count == `ISA_ACK_BIT);

  // Main sequencer; clears are written before sets so a set in the same cycle wins
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      bit_count <= 4'h0;
      serial_shift_reg <= 8'h00;
      tx_shift <= 8'h00;
      ack_drive <= 1'b0;
      pend_hit <= 1'b0;
      scl_hold <= 1'b0;
      hi_seen <= 1'b0;
      tx_active <= 1'b0;
      tx_nack <= 1'b1;
      rw_status <= 1'b0;
      data_status <= 1'b0;
      start_seen <= 1'b0;
      stop_seen <= 1'b0;
      rx_tx_buffer <= 8'h00;
      slave_address_reg <= 8'h00;
      buffer_full_flag <= 1'b0;
      receive_overflow_flag <= 1'b0;
      update_address_flag <= 1'b0;
      port_interrupt_flag <= 1'b0;
    end else begin
      // Firmware side accesses
      if (buf_rd) begin
        buffer_full_flag <= 1'b0;
      end
      if (overflow_clr) begin
        receive_overflow_flag <= 1'b0;
      end
      if (interrupt_clr) begin
        port_interrupt_flag <= 1'b0;
      end
      if (addr_wr) begin
        slave_address_reg <= addr_wdata;
        if (update_address_flag) begin
          update_address_flag <= 1'b0;
          scl_hold <= 1'b0;
        end
      end
      if (clock_release_set) begin
        scl_hold <= 1'b0;
      end
      // A buffer write also loads the outgoing shifter
      if (buf_wr) begin
        rx_tx_buffer <= buf_wdata;
        tx_shift <= buf_wdata;
      end

      if (!port_active) begin
        // Disabled port: sequencer idle, bus released, start/stop status cleared
        state <= ST_IDLE;
        bit_count <= 4'h0;
        ack_drive <= 1'b0;
        scl_hold <= 1'b0;
        hi_seen <= 1'b0;
        tx_active <= 1'b0;
        start_seen <= 1'b0;
        stop_seen <= 1'b0;
      end else if (start_det) begin
        start_seen <= 1'b1;
        stop_seen <= 1'b0;
        if (has_ss_int(mode_select_field)) begin
          port_interrupt_flag <= 1'b1;
        end
        if (slave_on) begin
          state <= ST_ADDR;
        end
        bit_count <= 4'h0;
        ack_drive <= 1'b0;
        tx_active <= 1'b0;
      end else if (stop_det) begin
        stop_seen <= 1'b1;
        start_seen <= 1'b0;
        if (has_ss_int(mode_select_field)) begin
          port_interrupt_flag <= 1'b1;
        end
        state <= ST_IDLE;
        bit_count <= 4'h0;
        ack_drive <= 1'b0;
        tx_active <= 1'b0;
        hi_seen <= 1'b0;
      end else begin
        // Bit counting and sampling on rising clock
        if (scl_rise && (state != ST_IDLE) && (bit_count != `ISA_ACK_BIT)) begin
          bit_count <= bit_count + 4'h1;
          if (rx_state && (bit_count != `ISA_BYTE_BITS)) begin
            serial_shift_reg <= {serial_shift_reg[6:0], sda_s};
          end
          if ((state == ST_TX) && (bit_count == `ISA_BYTE_BITS)) begin
            tx_nack <= sda_s; // Master answer on the ninth rise
          end
        end

        // Eighth fall: decide whether the byte is ours and whether to acknowledge
        if (eighth_fall && rx_state) begin
          case (state)
            ST_ADDR: pend_hit <= addr_hit;
            ST_ADDR_LO: pend_hit <= lo_hit;
            default: pend_hit <= 1'b1;
          endcase
          case (state)
            ST_ADDR: ack_drive <= addr_hit && !buffer_full_flag && !receive_overflow_flag;
            ST_ADDR_LO: ack_drive <= lo_hit && !buffer_full_flag && !receive_overflow_flag;
            default: ack_drive <= !buffer_full_flag && !receive_overflow_flag;
          endcase
        end

        // Transmit bits change on falling clock; release data for the master answer
        if ((state == ST_TX) && scl_fall) begin
          if ((bit_count != 4'h0) && (bit_count < `ISA_BYTE_BITS)) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
          end
          if (bit_count == `ISA_BYTE_BITS) begin
            tx_active <= 1'b0;
          end
        end

        // Ninth fall: commit the received byte
        if (ninth_fall && rx_state) begin
          ack_drive <= 1'b0;
          bit_count <= 4'h0;
          if (pend_hit) begin
            port_interrupt_flag <= 1'b1;
            if (ack_drive) begin
              rx_tx_buffer <= serial_shift_reg;
              buffer_full_flag <= 1'b1;
            end else begin
              receive_overflow_flag <= 1'b1;
            end
          end
          case (state)
            ST_ADDR: begin
              if (!pend_hit || !ack_drive) begin
                state <= ST_IDLE;
              end else begin
                rw_status <= serial_shift_reg[0];
                data_status <= 1'b0;
                if (ten_bit && !serial_shift_reg[0]) begin
                  update_address_flag <= 1'b1;
                  scl_hold <= 1'b1;
                  hi_seen <= 1'b1;
                  state <= ST_ADDR_LO;
                end else if (ten_bit && !hi_seen) begin
                  state <= ST_IDLE; // A 10-bit read needs the write-form sequence first
                end else if (serial_shift_reg[0]) begin
                  scl_hold <= 1'b1;
                  tx_active <= 1'b1;
                  state <= ST_TX;
                end else begin
                  state <= ST_RX;
                end
              end
            end
            ST_ADDR_LO: begin
              if (pend_hit && ack_drive) begin
                update_address_flag <= 1'b1;
                scl_hold <= 1'b1;
                state <= ST_RX;
              end else begin
                hi_seen <= 1'b0;
                state <= ST_IDLE;
              end
            end
            default: begin
              data_status <= 1'b1;
            end
          endcase
        end

        // Ninth fall after a transmitted byte: stop on no-acknowledge, else stretch
        if (ninth_fall && (state == ST_TX)) begin
          bit_count <= 4'h0;
          port_interrupt_flag <= 1'b1;
          if (tx_nack) begin
            state <= ST_IDLE;
            rw_status <= 1'b0;
            data_status <= 1'b0;
          end else begin
            scl_hold <= 1'b1;
            tx_active <= 1'b1;
            data_status <= 1'b1;
          end
        end
      end
    end
  end

  // Pins are open drain: level is always low, the enable decides; active only if both pins are inputs
  wire sda_low = ack_drive || ((state == ST_TX) && tx_active && !tx_shift[7]);
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = !(pins_owned && scl_hold);
  assign sda_oe_n = !(pins_owned && sda_low);

  // Readback images; the shift register deliberately has no path out
  assign port_status_reg = {2'b00, data_status, stop_seen, start_seen, rw_status,
                            update_address_flag, buffer_full_flag};
  assign port_control_reg = {1'b0, receive_overflow_flag, port_enable, !scl_hold, mode_select_field};

endmodule

`default_nettype wire

//--- core/isa_sync2.v
`timescale 1ns/10ps
`default_nettype none

module isa_sync2 #(
  parameter WIDTH = 2
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] d_in,
  output wire [WIDTH-1:0] q_out
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // Idle bus lines are high, so both stages reset high to avoid a false start
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= {WIDTH{1'b1}};
      stage2 <= {WIDTH{1'b1}};
    end else begin
      stage1 <= d_in;
      stage2 <= stage1;
    end
  end

  assign q_out = stage2;

endmodule

`default_nettype wire

//--- pkg/isa_defines.vh
`ifndef ISA_DEFINES_VH
`define ISA_DEFINES_VH

// Two-wire mode codes of the mode select field
`define ISA_MODE_SLV7 4'h6
`define ISA_MODE_SLV10 4'h7
`define ISA_MODE_MST_IDLE 4'hb
`define ISA_MODE_SLV7_SS 4'he
`define ISA_MODE_SLV10_SS 4'hf

// Top five bits of a 10-bit first address byte
`define ISA_HI10_PATTERN 5'h1e

// Control register bit positions
`define ISA_CTL_OVERFLOW 6
`define ISA_CTL_ENABLE 5
`define ISA_CTL_RELEASE 4

// Status register bit positions
`define ISA_ST_DATA 5
`define ISA_ST_STOP 4
`define ISA_ST_START 3
`define ISA_ST_RW 2
`define ISA_ST_UA 1
`define ISA_ST_BF 0

// Bit count of a byte plus its acknowledge slot
`define ISA_BYTE_BITS 4'h8
`define ISA_ACK_BIT 4'h9

`endif

//--- tb/isa_engine_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "isa_defines.vh"
module isa_engine_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic port_enable,
  input wire logic [1:0] port_c_direction,
  input wire logic addr_wr,
  input wire logic buf_rd,
  input wire logic buf_wr,
  input wire logic overflow_clr,
  input wire logic clock_release_set,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [7:0] rx_tx_buffer,
  input wire logic buffer_full_flag,
  input wire logic receive_overflow_flag,
  input wire logic update_address_flag,
  input wire logic port_interrupt_flag,
  input wire logic [7:0] port_status_reg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Receive acknowledge: pulled low, then held for most of one serial clock period
  sequence s_ack_start;
    $fell(sda_oe_n) && !port_status_reg[`ISA_ST_RW];
  endsequence
  sequence s_ack_hold;
    ##1 !sda_oe_n [*6];
  endsequence
  a_pin_level: assert property (!scl_out && !sda_out) else $error("pin level high");
  a_off_quiet: assert property (!port_enable || port_c_direction != 2'h3 |-> scl_oe_n && sda_oe_n)
    else $error("pins driven while off");
  a_ack_gated: assert property (s_ack_start |-> !buffer_full_flag && !receive_overflow_flag)
    else $error("ack while full");
  a_ack_width: assert property (s_ack_start |-> s_ack_hold) else $error("ack too short");
  a_full_keeps: assert property ((buffer_full_flag || receive_overflow_flag) && !buf_wr |=> $stable(rx_tx_buffer))
    else $error("buffer loaded while full");
  a_ov_sticky: assert property (receive_overflow_flag && !overflow_clr |=> receive_overflow_flag)
    else $error("overflow lost");
  a_bf_read: assert property (buf_rd |=> !buffer_full_flag || $changed(rx_tx_buffer))
    else $error("full kept after read");
  a_irq_load: assert property ($rose(buffer_full_flag) |-> port_interrupt_flag)
    else $error("load without interrupt");
  a_ua_hold: assert property ($rose(update_address_flag) |-> buffer_full_flag && port_interrupt_flag ##1 !scl_oe_n)
    else $error("update flag without hold");
  a_ua_clear: assert property (update_address_flag && addr_wr |=> !update_address_flag && scl_oe_n)
    else $error("address write kept hold");
  a_release: assert property (!scl_oe_n && clock_release_set && !update_address_flag |=> scl_oe_n)
    else $error("release ignored");
endmodule
bind isa_engine isa_engine_chk u_chk (.*);
`default_nettype wire

//--- tb/isa_engine_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "isa_defines.vh"
module isa_engine_tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b0;
  logic [1:0] dir = 2'h3;
  logic [3:0] mode = 4'h0;
  logic [5:0] stb = 6'h00;
  logic [7:0] wd = 8'h00;
  wire logic scl_m, sda_m, scl_oe_n, sda_oe_n, bf, ov, ua, irq;
  wire logic [7:0] buffer, status, sadr, ctl;
  // Open-drain lines with pull-ups
  wire logic scl_w = scl_m & scl_oe_n;
  wire logic sda_w = sda_m & sda_oe_n;
  wire logic [7:0] flg = {4'h0, ov, ua, bf, irq};
  int fails = 0;
  int tests_run = 0;
  isa_engine dut (.clock(clock), .reset_n(reset_n), .port_enable(en), .mode_select_field(mode),
    .port_c_direction(dir), .addr_wr(stb[0]), .addr_wdata(wd), .buf_rd(stb[1]), .buf_wr(stb[2]), .buf_wdata(wd),
    .overflow_clr(stb[3]), .interrupt_clr(stb[4]), .clock_release_set(stb[5]), .scl_in(scl_w), .scl_out(),
    .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n), .rx_tx_buffer(buffer),
    .slave_address_reg(sadr), .buffer_full_flag(bf), .receive_overflow_flag(ov), .update_address_flag(ua),
    .port_interrupt_flag(irq), .port_status_reg(status), .port_control_reg(ctl));
  isa_master_model m (.scl_m(scl_m), .sda_m(sda_m), .scl_w(scl_w), .sda_w(sda_w));
  // System clock
  initial begin
    forever #25 clock = ~clock;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Firmware strobes: one cycle wide, result visible after the taking edge
  task automatic fw(input logic [5:0] s, input logic [7:0] d);
    @(posedge clock);
    stb <= s;
    wd <= d;
    @(posedge clock);
    stb <= 6'h00;
    #1;
  endtask
  task automatic settle();
    repeat (5) @(posedge clock);
    #1;
  endtask
  // Also clears every flag and sets address a0
  task automatic cfg(input logic e, input logic [1:0] d, input logic [3:0] md);
    @(posedge clock);
    en <= e;
    dir <= d;
    mode <= md;
    fw(6'h1b, 8'ha0);
  endtask
  task automatic snd(input logic [7:0] d, input logic e);
    logic [7:0] q;
    logic a;
    m.byte_x(d, q, a);
    chk("ack", 8'(e), 8'(a));
    settle();
  endtask
  task automatic rdb(input logic [7:0] e);
    logic [7:0] q;
    logic a;
    m.byte_x(8'hff, q, a);
    chk("read data", e, q);
    settle();
  endtask
  task automatic t_write7();
    cfg(1'b1, 2'h3, `ISA_MODE_SLV7);
    m.start();
    snd(8'ha0, 1'b0);
    chk("buffer", 8'ha0, buffer);
    chk("flags", 8'h03, flg);
    chk("rw", 8'h00, 8'(status[`ISA_ST_RW]));
    fw(6'h10, 8'h00);
    snd(8'h5b, 1'b1);
    chk("buffer", 8'ha0, buffer);
    chk("flags", 8'h0b, flg);
    chk("control", 8'h76, ctl);
    chk("data bit", 8'h01, 8'(status[`ISA_ST_DATA]));
    fw(6'h02, 8'h00);
    chk("flags", 8'h09, flg);
    fw(6'h18, 8'h00);
    chk("flags", 8'h00, flg);
    m.stop();
  endtask
  task automatic t_miss();
    m.start();
    snd(8'ha2, 1'b1);
    chk("flags", 8'h00, flg);
    m.stop();
  endtask
  task automatic t_read7();
    m.start();
    snd(8'ha1, 1'b0);
    chk("rw", 8'h01, 8'(status[`ISA_ST_RW]));
    fw(6'h16, 8'h3c);
    chk("hold", 8'h00, 8'(scl_oe_n));
    chk("control", 8'h26, ctl);
    fw(6'h20, 8'h00);
    chk("control", 8'h36, ctl);
    rdb(8'h3c);
    chk("irq", 8'h01, 8'(irq));
    m.stop();
  endtask
  task automatic t_ten();
    cfg(1'b1, 2'h3, `ISA_MODE_SLV10);
    fw(6'h01, 8'hf2);
    m.start();
    snd(8'hf2, 1'b0);
    chk("flags", 8'h07, flg);
    fw(6'h13, 8'h34);
    chk("address", 8'h34, sadr);
    chk("flags", 8'h00, flg);
    snd(8'h34, 1'b0);
    chk("flags", 8'h07, flg);
    fw(6'h13, 8'hf2);
    chk("hold", 8'h01, 8'(scl_oe_n));
    m.start();
    snd(8'hf3, 1'b0);
    chk("flags", 8'h03, flg);
    fw(6'h16, 8'h81);
    fw(6'h30, 8'h00);
    rdb(8'h81);
    m.stop();
  endtask
  task automatic t_off(input logic e, input logic [1:0] d);
    cfg(e, d, `ISA_MODE_SLV7);
    m.start();
    snd(8'ha0, 1'b1);
    if (!e) chk("flags", 8'h00, flg);
    m.stop();
  endtask
  task automatic t_modes();
    logic [3:0] md [5] = '{`ISA_MODE_SLV7, `ISA_MODE_SLV10, `ISA_MODE_MST_IDLE, `ISA_MODE_SLV7_SS, `ISA_MODE_SLV10_SS};
    logic [4:0] ss = 5'b11100;
    logic [4:0] ak = 5'b10110;
    for (int i = 0; i < 5; i++) begin
      cfg(1'b1, 2'h3, md[i]);
      m.start();
      settle();
      chk("start irq", 8'(ss[i]), 8'(irq));
      chk("start bit", 8'h01, 8'(status[`ISA_ST_START]));
      fw(6'h1a, 8'h00);
      snd(8'ha0, ak[i]);
      fw(6'h1a, 8'h00);
      m.stop();
      settle();
      chk("stop irq", 8'(ss[i]), 8'(irq));
      chk("stop bit", 8'h01, 8'(status[`ISA_ST_STOP]));
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Main sequence; reset and synchroniser settling come first
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_write7();
    t_miss();
    t_read7();
    t_ten();
    t_off(1'b0, 2'h3);
    t_off(1'b1, 2'h1);
    t_modes();
    conclude();
  end
  // Tests need about 80 us; a stuck clock stretch would hang the master
  initial begin
    #2000000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire

//--- tb/isa_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module isa_master_model (
  output var logic scl_m,
  output var logic sda_m,
  input wire logic scl_w,
  input wire logic sda_w
);
  // Released lines sit at the pull-up level between frames
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // Start or repeated start: data falls while clock high
  task automatic start();
    #100 sda_m = 1'b1;
    #100 scl_m = 1'b1;
    #200 sda_m = 1'b0;
    #200 scl_m = 1'b0;
  endtask
  // Stop: data rises while clock high
  task automatic stop();
    #100 sda_m = 1'b0;
    #100 scl_m = 1'b1;
    #200 sda_m = 1'b1;
    #200;
  endtask
  // Data moves midway through the low phase so no false start or stop is seen
  task automatic bit_x(input logic b, output logic r);
    #100 sda_m = b;
    #100 scl_m = 1'b1;
    while (!scl_w) #50; // Slave may stretch the clock
    #100 r = sda_w;
    #100 scl_m = 1'b0;
  endtask
  // Eight bits MSB first, then a released acknowledge slot
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(1'b1, a);
  endtask
endmodule
`default_nettype wire
